// ### src/ciu_pkg.sv
// constants and types shared by the cpu interrupt unit
package ciu_pkg;
    localparam int CIU_NUM_PERIPH = 8;
    localparam int CIU_NUM_PINS = 8;
    localparam int CIU_PC_W = 16;
    localparam int CIU_SPD_W = 8;
    localparam int CIU_REG_W = 8;
    localparam int CIU_CTX_W = 11 * 8;
    localparam int CIU_STACK_DEPTH = 2;
    localparam int CIU_CFG_GIE_BIT = 7;
    localparam int CIU_CFG_SWI_BIT = 6;
    localparam int CIU_RETI_TMR_BIT = 0;
    localparam int CIU_RETI_VEC_BIT = 1;
    localparam int CIU_RETI_SPD_BIT = 2;
    localparam int CIU_CLK_MHZ = 20;
    localparam int CIU_REQ_LAG_CYC = 2;
    localparam int CIU_DATA_PUSH_CYC = 4;
    localparam int CIU_PMEM_BLOCK_CYC = 4;
    localparam int CIU_LATENCY_CYC = 3;
    localparam int CIU_REFILL_CYC = 2;
    localparam logic [15:0] CIU_VEC_RST = 16'h0000;
    localparam logic [7:0] CIU_SPD_RST = 8'h00;
    typedef enum logic [1:0] {
        CIU_IDLE,
        CIU_ENTER,
        CIU_REFILL
    } ciu_state_type;
endpackage

// ### src/ciu_top.sv
// interrupt gathering, vectoring and context shadowing for the core
// Contract
// - eight port pins each raise interrupts on a selectable rising or falling edge
// - parallel slave has no request; it borrows a port pin input
// - software interrupt fires only while its enable bit is set; bit is its flag
// - a source interrupts only with its enable and global enable set
// - one writable vector in high and low registers gives the target
// - entry saves pc in saved pc registers; return reloads pc from them
// - return option bit 1 writes pc plus one into the vector
// - request drops two cycles after a source flag clears
// - every shadowed register has a two-level push-down stack
// - context registers stay live on entry, copied to shadow, restored on return
// - interrupt save is separate from the subroutine call stack
// - data pair pushed four cycles after entry
// - global enable clears on entry, sets on return
// - global enable is config bit 7, writable anytime; a write in an entry or return cycle loses to the clear or set
// - triggers while global enable is clear stay latched until enabled
// - sync bit zero adds two cycles on port pin interrupts
// - program ram access blocks interrupts four cycles; external access does not
// - entry pushes current speed, then loads interrupt speed
// - latency three cycles, plus speed change delay when speeds differ
// - return option bit 2 restores pre-interrupt speed
// - return option bit 0 adds working register to timer zero count
// - return takes one cycle plus two refill cycles
`timescale 1ns/10ps
`default_nettype none
module ciu_top
    import ciu_pkg::*;
(
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic [ciu_pkg::CIU_NUM_PINS-1:0] pin_in,
    input wire logic [ciu_pkg::CIU_NUM_PINS-1:0] pin_rise_sel_in,
    input wire logic [ciu_pkg::CIU_NUM_PINS-1:0] pin_en_in,
    input wire logic [ciu_pkg::CIU_NUM_PINS-1:0] pin_flag_clr_in,
    input wire logic fuse_sync_in,
    input wire logic [ciu_pkg::CIU_NUM_PERIPH-1:0] periph_flag_in,
    input wire logic [ciu_pkg::CIU_NUM_PERIPH-1:0] periph_en_in,
    input wire logic cfg_wr_in,
    input wire logic [7:0] cfg_wdata_in,
    input wire logic swi_exec_in,
    input wire logic vec_wr_in,
    input wire logic [ciu_pkg::CIU_PC_W-1:0] vec_wdata_in,
    input wire logic isr_speed_wr_in,
    input wire logic [ciu_pkg::CIU_SPD_W-1:0] isr_speed_wdata_in,
    input wire logic speed_wr_in,
    input wire logic [ciu_pkg::CIU_SPD_W-1:0] speed_wdata_in,
    input wire logic [ciu_pkg::CIU_SPD_W-1:0] speed_change_cyc_in,
    input wire logic pmem_ram_access_in,
    input wire logic boundary_in,
    input wire logic [ciu_pkg::CIU_PC_W-1:0] pc_in,
    input wire logic [ciu_pkg::CIU_CTX_W-1:0] ctx_in,
    input wire logic [ciu_pkg::CIU_REG_W-1:0] working_reg_in,
    input wire logic [15:0] pmem_data_in,
    input wire logic reti_in,
    input wire logic [2:0] reti_opt_in,
    output logic irq_req_out,
    output logic take_out,
    output logic [ciu_pkg::CIU_PC_W-1:0] target_pc_out,
    output logic pc_load_out,
    output logic restore_out,
    output logic [ciu_pkg::CIU_CTX_W-1:0] ctx_restore_out,
    output logic [15:0] pmem_data_restore_out,
    output logic timer_add_out,
    output logic [ciu_pkg::CIU_REG_W-1:0] timer_add_val_out,
    output logic stall_out,
    output logic [7:0] cfg_out,
    output logic [ciu_pkg::CIU_PC_W-1:0] vector_out,
    output logic [ciu_pkg::CIU_SPD_W-1:0] current_speed_out,
    output logic [ciu_pkg::CIU_PC_W-1:0] saved_pc_out,
    output logic [ciu_pkg::CIU_NUM_PINS-1:0] pin_flag_out,
    output logic in_isr_out
);
    import ciu_pkg::*;

    logic [CIU_NUM_PINS-1:0] sync_a_ff, sync_b_ff, extra_a_ff, extra_b_ff, prev_ff;
    logic [CIU_NUM_PINS-1:0] pin_flag_ff;
    logic [7:0] cfg_ff;
    logic [CIU_PC_W-1:0] vector_high_low_ff;
    logic [CIU_SPD_W-1:0] isr_speed_reg_ff, current_speed_reg_ff;
    logic [CIU_PC_W-1:0] pc_stk_ff [CIU_STACK_DEPTH];
    logic [CIU_SPD_W-1:0] spd_stk_ff [CIU_STACK_DEPTH];
    logic [CIU_CTX_W-1:0] ctx_stk_ff [CIU_STACK_DEPTH];
    logic [15:0] data_stk_ff [CIU_STACK_DEPTH];
    logic [1:0] depth_ff;
    logic [2:0] data_push_cnt_ff;
    logic [2:0] block_cnt_ff;
    logic [CIU_SPD_W-1:0] wait_cnt_ff;
    logic [1:0] pend_pipe_ff;
    ciu_state_type state_ff;
    logic [CIU_NUM_PINS-1:0] pin_level, pin_prev_src, pin_edge;
    logic pending, take;

    // pins pass two flops; sync=0 adds two more stages
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sync_a_ff <= '0;
            sync_b_ff <= '0;
            extra_a_ff <= '0;
            extra_b_ff <= '0;
            prev_ff <= '0;
        end else begin
            sync_a_ff <= pin_in;
            sync_b_ff <= sync_a_ff;
            extra_a_ff <= sync_b_ff;
            extra_b_ff <= extra_a_ff;
            prev_ff <= pin_level;
        end
    end

    assign pin_level = fuse_sync_in ? sync_b_ff : extra_b_ff;
    assign pin_prev_src = prev_ff;
    assign pin_edge = (pin_rise_sel_in & pin_level & ~pin_prev_src)
        | (~pin_rise_sel_in & ~pin_level & pin_prev_src);

    // edge flags latch regardless of global enable; set wins over clear
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pin_flag_ff <= '0;
        end else begin
            pin_flag_ff <= (pin_flag_ff & ~pin_flag_clr_in) | pin_edge;
        end
    end

    // one request combining every enabled flag; parallel slave uses a pin flag
    assign pending = |(pin_flag_ff & pin_en_in) | |(periph_flag_in & periph_en_in)
        | (cfg_ff[CIU_CFG_SWI_BIT] & swi_exec_in);

    // two-stage lag so a cleared flag drops the request two cycles later
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pend_pipe_ff <= '0;
        end else begin
            pend_pipe_ff <= {pend_pipe_ff[0], pending};
        end
    end

    // nesting beyond the stack depth is refused to avoid clobbering shadow
    assign take = (state_ff == CIU_IDLE) && pend_pipe_ff[1] && cfg_ff[CIU_CFG_GIE_BIT]
        && boundary_in && (block_cnt_ff == 3'h0) && !pmem_ram_access_in
        && (depth_ff < 2'(CIU_STACK_DEPTH)) && !reti_in;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            block_cnt_ff <= '0;
        end else if (pmem_ram_access_in) begin
            block_cnt_ff <= 3'(CIU_PMEM_BLOCK_CYC - 1);
        end else if (block_cnt_ff != 3'h0) begin
            block_cnt_ff <= block_cnt_ff - 3'h1;
        end
    end

    // configuration: global enable and software interrupt enable
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cfg_ff <= '0;
        end else begin
            if (cfg_wr_in) begin
                cfg_ff <= cfg_wdata_in;
            end
            if (take) begin
                cfg_ff[CIU_CFG_GIE_BIT] <= 1'b0;
            end else if (reti_in && depth_ff != 2'h0) begin
                cfg_ff[CIU_CFG_GIE_BIT] <= 1'b1;
            end
        end
    end

    // vector register pair
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            vector_high_low_ff <= CIU_VEC_RST;
        end else if (reti_in && depth_ff != 2'h0 && reti_opt_in[CIU_RETI_VEC_BIT]) begin
            vector_high_low_ff <= pc_in + 16'h0001;
        end else if (vec_wr_in) begin
            vector_high_low_ff <= vec_wdata_in;
        end
    end

    // speed registers
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            isr_speed_reg_ff <= CIU_SPD_RST;
            current_speed_reg_ff <= CIU_SPD_RST;
        end else begin
            if (isr_speed_wr_in) begin
                isr_speed_reg_ff <= isr_speed_wdata_in;
            end
            if (take) begin
                current_speed_reg_ff <= isr_speed_reg_ff;
            end else if (reti_in && depth_ff != 2'h0 && reti_opt_in[CIU_RETI_SPD_BIT]) begin
                current_speed_reg_ff <= spd_stk_ff[0];
            end else if (speed_wr_in) begin
                current_speed_reg_ff <= speed_wdata_in;
            end
        end
    end

    // shadow stacks, private to interrupts, apart from the call stack
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            depth_ff <= '0;
            for (int i = 0; i < CIU_STACK_DEPTH; i++) begin
                pc_stk_ff[i] <= '0;
                spd_stk_ff[i] <= '0;
                ctx_stk_ff[i] <= '0;
            end
        end else if (take) begin
            depth_ff <= depth_ff + 2'h1;
            pc_stk_ff[0] <= pc_in;
            pc_stk_ff[1] <= pc_stk_ff[0];
            spd_stk_ff[0] <= current_speed_reg_ff;
            spd_stk_ff[1] <= spd_stk_ff[0];
            ctx_stk_ff[0] <= ctx_in;
            ctx_stk_ff[1] <= ctx_stk_ff[0];
        end else if (reti_in && depth_ff != 2'h0) begin
            depth_ff <= depth_ff - 2'h1;
            pc_stk_ff[0] <= pc_stk_ff[1];
            spd_stk_ff[0] <= spd_stk_ff[1];
            ctx_stk_ff[0] <= ctx_stk_ff[1];
        end
    end

    // data pair pushed late so a pending program read lands first
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            data_push_cnt_ff <= '0;
            data_stk_ff[0] <= '0;
            data_stk_ff[1] <= '0;
        end else if (take) begin
            data_push_cnt_ff <= 3'(CIU_DATA_PUSH_CYC);
        end else if (data_push_cnt_ff != 3'h0) begin
            data_push_cnt_ff <= data_push_cnt_ff - 3'h1;
            if (data_push_cnt_ff == 3'h1) begin
                data_stk_ff[0] <= pmem_data_in;
                data_stk_ff[1] <= data_stk_ff[0];
            end
        end else if (reti_in && depth_ff != 2'h0) begin
            data_stk_ff[0] <= data_stk_ff[1];
        end
    end

    // entry latency and return refill sequencing
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_ff <= CIU_IDLE;
            wait_cnt_ff <= '0;
        end else begin
            case (state_ff)
                CIU_IDLE: begin
                    if (take) begin
                        state_ff <= CIU_ENTER;
                        wait_cnt_ff <= (isr_speed_reg_ff == current_speed_reg_ff)
                            ? 8'(CIU_LATENCY_CYC - 1)
                            : 8'(CIU_LATENCY_CYC - 1) + speed_change_cyc_in;
                    end else if (reti_in && depth_ff != 2'h0) begin
                        state_ff <= CIU_REFILL;
                        wait_cnt_ff <= 8'(CIU_REFILL_CYC - 1);
                    end
                end
                CIU_ENTER, CIU_REFILL: begin
                    if (wait_cnt_ff == 8'h00) begin
                        state_ff <= CIU_IDLE;
                    end else begin
                        wait_cnt_ff <= wait_cnt_ff - 8'h01;
                    end
                end
                default: state_ff <= CIU_IDLE;
            endcase
        end
    end

    // registered core-facing outputs
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            irq_req_out <= 1'b0;
            take_out <= 1'b0;
            target_pc_out <= '0;
            pc_load_out <= 1'b0;
            restore_out <= 1'b0;
            ctx_restore_out <= '0;
            pmem_data_restore_out <= '0;
            timer_add_out <= 1'b0;
            timer_add_val_out <= '0;
            stall_out <= 1'b0;
        end else begin
            irq_req_out <= pend_pipe_ff[1] & cfg_ff[CIU_CFG_GIE_BIT];
            take_out <= take;
            pc_load_out <= take | (reti_in && depth_ff != 2'h0);
            target_pc_out <= take ? vector_high_low_ff : pc_stk_ff[0];
            restore_out <= reti_in && depth_ff != 2'h0;
            ctx_restore_out <= ctx_stk_ff[0];
            pmem_data_restore_out <= data_stk_ff[0];
            timer_add_out <= reti_in && depth_ff != 2'h0 && reti_opt_in[CIU_RETI_TMR_BIT];
            timer_add_val_out <= working_reg_in;
            stall_out <= take || (reti_in && depth_ff != 2'h0)
                || ((state_ff != CIU_IDLE) && (wait_cnt_ff != 8'h00));
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cfg_out <= '0;
            vector_out <= CIU_VEC_RST;
            current_speed_out <= CIU_SPD_RST;
            saved_pc_out <= '0;
            pin_flag_out <= '0;
            in_isr_out <= 1'b0;
        end else begin
            cfg_out <= cfg_ff;
            vector_out <= vector_high_low_ff;
            current_speed_out <= current_speed_reg_ff;
            saved_pc_out <= pc_stk_ff[0];
            pin_flag_out <= pin_flag_ff;
            in_isr_out <= depth_ff != 2'h0;
        end
    end
endmodule
`default_nettype wire

// ### test/ciu_chk.sv
// port assertions for the cpu interrupt unit
`timescale 1ns/10ps
`default_nettype none
module ciu_chk
    import ciu_pkg::*;
(
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic [ciu_pkg::CIU_NUM_PINS-1:0] pin_en_in,
    input wire logic [ciu_pkg::CIU_NUM_PERIPH-1:0] periph_en_in,
    input wire logic cfg_wr_in,
    input wire logic [7:0] cfg_wdata_in,
    input wire logic irq_req_out,
    input wire logic take_out,
    input wire logic [ciu_pkg::CIU_PC_W-1:0] target_pc_out,
    input wire logic pc_load_out,
    input wire logic restore_out,
    input wire logic stall_out,
    input wire logic [7:0] cfg_out,
    input wire logic [ciu_pkg::CIU_PC_W-1:0] vector_out
);
    // nesting depth as seen from the pulses alone
    logic [1:0] depth_ff;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            depth_ff <= 2'h0;
        end else if (take_out) begin
            depth_ff <= depth_ff + 2'h1;
        end else if (restore_out && depth_ff != 2'h0) begin
            depth_ff <= depth_ff - 2'h1;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    sequence quiet_s;
        (periph_en_in == 8'h00 && pin_en_in == 8'h00 && !cfg_out[CIU_CFG_SWI_BIT]) [*4];
    endsequence
    sequence stall_s;
        stall_out [*3];
    endsequence
    take_load_a: assert property (take_out |-> pc_load_out && target_pc_out == vector_out)
        else $error("take without vector load");
    gie_clear_a: assert property (take_out |=> !cfg_out[CIU_CFG_GIE_BIT])
        else $error("global enable kept on entry");
    gie_gate_a: assert property (take_out |-> cfg_out[CIU_CFG_GIE_BIT])
        else $error("take while globally disabled");
    entry_stall_a: assert property (take_out |-> stall_s)
        else $error("entry stall too short");
    take_pulse_a: assert property (take_out |=> !take_out)
        else $error("take longer than one cycle");
    nest_depth_a: assert property (take_out |-> depth_ff < 2'h2)
        else $error("third level taken");
    quiet_req_a: assert property (quiet_s |=> !irq_req_out)
        else $error("request with every source disabled");
    cfg_write_a: assert property (cfg_wr_in |-> ##2
        cfg_out[6:0] == $past(cfg_wdata_in[6:0], 2))
        else $error("config write lost");
endmodule
bind ciu_top ciu_chk chk (.clk_in(clk_in), .resetn_in(resetn_in), .pin_en_in(pin_en_in),
    .periph_en_in(periph_en_in), .cfg_wr_in(cfg_wr_in), .cfg_wdata_in(cfg_wdata_in),
    .irq_req_out(irq_req_out), .take_out(take_out), .target_pc_out(target_pc_out),
    .pc_load_out(pc_load_out), .restore_out(restore_out), .stall_out(stall_out),
    .cfg_out(cfg_out), .vector_out(vector_out));
`default_nettype wire

// ### test/ciu_core_model.sv
// core pipeline stand-in: boundaries and program counter
`timescale 1ns/10ps
`default_nettype none
module ciu_core_model
    import ciu_pkg::*;
(
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic stall_in,
    input wire logic pc_load_in,
    input wire logic [ciu_pkg::CIU_PC_W-1:0] target_pc_in,
    output logic boundary_out,
    output logic [ciu_pkg::CIU_PC_W-1:0] pc_out
);
    logic [CIU_PC_W-1:0] pc_ff;
    // no boundary while entry or refill stalls the pipe
    assign boundary_out = resetn_in && !stall_in;
    assign pc_out = pc_ff;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pc_ff <= 16'h0100;
        end else if (pc_load_in) begin
            pc_ff <= target_pc_in;
        end else if (boundary_out) begin
            pc_ff <= pc_ff + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// ### test/testbench.sv
// self-checking bench for the cpu interrupt unit
`timescale 1ns/10ps
`default_nettype none
`define CHECK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module testbench;
    import ciu_pkg::*;
    logic clk_in = 1'b0, resetn_in = 1'b0, fuse_sync_in = 1'b1, cfg_wr_in = 1'b0;
    logic swi_exec_in = 1'b0, vec_wr_in = 1'b0, isr_speed_wr_in = 1'b0, speed_wr_in = 1'b0;
    logic pmem_ram_access_in = 1'b0, reti_in = 1'b0;
    logic [7:0] pin_in = 8'h00, pin_rise_sel_in = 8'h00, pin_en_in = 8'h00, pin_flag_clr_in = 8'h00;
    logic [7:0] periph_flag_in = 8'h00, periph_en_in = 8'h00, cfg_wdata_in = 8'h00;
    logic [7:0] isr_speed_wdata_in = 8'h00, speed_wdata_in = 8'h00, speed_change_cyc_in = 8'h00;
    logic [7:0] working_reg_in = 8'h00, timer_add_val_out, cfg_out, current_speed_out;
    logic [7:0] pin_flag_out, tmr_seen;
    logic [2:0] reti_opt_in = 3'h0;
    logic [15:0] vec_wdata_in = 16'h0000, pmem_data_in = 16'h0000, pc_in, pc_d2;
    logic [15:0] target_pc_out, pmem_data_restore_out, vector_out, saved_pc_out, pd_seen;
    logic [CIU_CTX_W-1:0] ctx_in = '0, ctx_restore_out, ctx_seen;
    logic boundary_in, irq_req_out, take_out, pc_load_out, restore_out, timer_add_out;
    logic stall_out, in_isr_out;
    int err_count = 0, num_checks = 0, cycles = 0, la, lb, lc;
    ciu_top DUT (.clk_in(clk_in), .resetn_in(resetn_in), .pin_in(pin_in),
        .pin_rise_sel_in(pin_rise_sel_in), .pin_en_in(pin_en_in), .pin_flag_clr_in(pin_flag_clr_in),
        .fuse_sync_in(fuse_sync_in), .periph_flag_in(periph_flag_in), .periph_en_in(periph_en_in),
        .cfg_wr_in(cfg_wr_in), .cfg_wdata_in(cfg_wdata_in), .swi_exec_in(swi_exec_in),
        .vec_wr_in(vec_wr_in), .vec_wdata_in(vec_wdata_in), .isr_speed_wr_in(isr_speed_wr_in),
        .isr_speed_wdata_in(isr_speed_wdata_in), .speed_wr_in(speed_wr_in),
        .speed_wdata_in(speed_wdata_in), .speed_change_cyc_in(speed_change_cyc_in),
        .pmem_ram_access_in(pmem_ram_access_in), .boundary_in(boundary_in), .pc_in(pc_in),
        .ctx_in(ctx_in), .working_reg_in(working_reg_in), .pmem_data_in(pmem_data_in),
        .reti_in(reti_in), .reti_opt_in(reti_opt_in), .irq_req_out(irq_req_out),
        .take_out(take_out), .target_pc_out(target_pc_out), .pc_load_out(pc_load_out),
        .restore_out(restore_out), .ctx_restore_out(ctx_restore_out),
        .pmem_data_restore_out(pmem_data_restore_out), .timer_add_out(timer_add_out),
        .timer_add_val_out(timer_add_val_out), .stall_out(stall_out), .cfg_out(cfg_out),
        .vector_out(vector_out), .current_speed_out(current_speed_out),
        .saved_pc_out(saved_pc_out), .pin_flag_out(pin_flag_out), .in_isr_out(in_isr_out));
    ciu_core_model core (.clk_in(clk_in), .resetn_in(resetn_in), .stall_in(stall_out),
        .pc_load_in(pc_load_out), .target_pc_in(target_pc_out), .boundary_out(boundary_in),
        .pc_out(pc_in));
    initial forever #25 clk_in = ~clk_in;
    // one stage only: read as take_out is first seen, it holds the pc of the take edge
    always @(posedge clk_in) begin
        pc_d2 <= pc_in;
        if (timer_add_out === 1'b1) tmr_seen <= timer_add_val_out;
        if (restore_out === 1'b1) ctx_seen <= ctx_restore_out;
        if (restore_out === 1'b1) pd_seen <= pmem_data_restore_out;
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic wait_take(output int n);
        n = 0;
        while (take_out !== 1'b1 && n < 40) begin
            @(posedge clk_in);
            n++;
        end
        `CHECK(take_out, 1'b1)
    endtask
    task automatic no_take(input int n);
        repeat (n) begin
            @(posedge clk_in);
            `CHECK(take_out, 1'b0)
        end
    endtask
    task automatic cfg_put(input logic [7:0] v);
        @(posedge clk_in);
        cfg_wr_in <= 1'b1;
        cfg_wdata_in <= v;
        @(posedge clk_in);
        cfg_wr_in <= 1'b0;
    endtask
    task automatic reti_go(input logic [2:0] opt, input logic [15:0] spc);
        int n;
        logic [15:0] rpc;
        @(posedge clk_in);
        reti_in <= 1'b1;
        reti_opt_in <= opt;
        @(posedge clk_in);
        rpc = pc_in;
        reti_in <= 1'b0;
        n = 0;
        while (pc_load_out !== 1'b1 && n < 10) begin
            @(posedge clk_in);
            n++;
        end
        `CHECK(target_pc_out, spc)
        repeat (4) @(posedge clk_in);
        `CHECK(cfg_out[CIU_CFG_GIE_BIT], 1'b1)
        if (opt[1]) `CHECK(vector_out, rpc + 16'h0001)
    endtask
    task automatic t_periph();
        int n;
        logic [15:0] spc;
        @(posedge clk_in);
        {vec_wr_in, speed_wr_in, isr_speed_wr_in, cfg_wr_in} <= 4'hf;
        vec_wdata_in <= 16'h1234;
        speed_wdata_in <= 8'h01;
        isr_speed_wdata_in <= 8'h05;
        cfg_wdata_in <= 8'h80;
        periph_flag_in <= 8'h04;
        pmem_ram_access_in <= 1'b1;
        ctx_in <= {11{8'ha5}};
        pmem_data_in <= 16'hbeef;
        @(posedge clk_in);
        {vec_wr_in, speed_wr_in, isr_speed_wr_in, cfg_wr_in} <= 4'h0;
        no_take(6);
        periph_en_in <= 8'h04;
        no_take(6);
        `CHECK(irq_req_out, 1'b1)
        pmem_ram_access_in <= 1'b0;
        wait_take(n);
        spc = pc_d2;
        `CHECK(target_pc_out, 16'h1234)
        ctx_in <= {11{8'h5a}};
        pmem_data_in <= 16'h1111;
        periph_flag_in <= 8'h00;
        repeat (6) @(posedge clk_in);
        `CHECK(current_speed_out, 8'h05)
        `CHECK(saved_pc_out, spc)
        `CHECK(in_isr_out, 1'b1)
        reti_go(3'b100, spc);
        `CHECK(current_speed_out, 8'h01)
        `CHECK(ctx_seen, {11{8'ha5}})
        `CHECK(pd_seen, 16'h1111)
        `CHECK(in_isr_out, 1'b0)
    endtask
    task automatic t_swi();
        int n;
        logic [15:0] spc;
        speed_change_cyc_in <= 8'h02;
        cfg_put(8'h80);
        swi_exec_in <= 1'b1;
        no_take(6);
        cfg_put(8'hc0);
        wait_take(n);
        spc = pc_d2;
        swi_exec_in <= 1'b0;
        working_reg_in <= 8'h3c;
        // speeds differ here, so entry stalls for the base latency plus the change delay
        n = 0;
        while (stall_out === 1'b1 && n < 20) begin
            @(posedge clk_in);
            n++;
        end
        `CHECK(n, CIU_LATENCY_CYC + 2)
        cfg_put(8'h00);
        reti_go(3'b011, spc);
        `CHECK(tmr_seen, 8'h3c)
    endtask
    task automatic pin_lat(input int p, input logic rise, input logic sync, output int n);
        logic [15:0] spc;
        @(posedge clk_in);
        fuse_sync_in <= sync;
        pin_rise_sel_in <= {8{rise}};
        pin_in <= {8{!rise}};
        repeat (5) @(posedge clk_in);
        pin_flag_clr_in <= 8'hff;
        @(posedge clk_in);
        pin_flag_clr_in <= 8'h00;
        pin_en_in[p] <= 1'b1;
        @(posedge clk_in);
        pin_in[p] <= rise;
        wait_take(n);
        `CHECK(pin_flag_out[p], 1'b1)
        spc = pc_d2;
        pin_flag_clr_in[p] <= 1'b1;
        pin_en_in[p] <= 1'b0;
        @(posedge clk_in);
        pin_flag_clr_in <= 8'h00;
        repeat (4) @(posedge clk_in);
        reti_go(3'b000, spc);
    endtask
    task automatic t_nest();
        int n;
        logic [15:0] s1, s2;
        cfg_put(8'h00);
        periph_en_in <= 8'h03;
        periph_flag_in <= 8'h01;
        no_take(8);
        cfg_put(8'h80);
        wait_take(n);
        s1 = pc_d2;
        periph_flag_in <= 8'h00;
        repeat (3) @(posedge clk_in);
        periph_flag_in <= 8'h02;
        cfg_put(8'h80);
        wait_take(n);
        s2 = pc_d2;
        repeat (3) @(posedge clk_in);
        cfg_put(8'h80);
        no_take(8);
        periph_flag_in <= 8'h00;
        cfg_put(8'h00);
        repeat (3) @(posedge clk_in);
        reti_go(3'b000, s2);
        reti_go(3'b000, s1);
    endtask
    initial begin
        repeat (10) @(posedge clk_in);
        resetn_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        `CHECK(cfg_out, 8'h00)
        `CHECK(vector_out, CIU_VEC_RST)
        `CHECK(current_speed_out, CIU_SPD_RST)
        t_periph();
        t_swi();
        pin_lat(3, 1'b1, 1'b1, la);
        pin_lat(3, 1'b1, 1'b0, lb);
        pin_lat(5, 1'b0, 1'b1, lc);
        `CHECK(lb, la + 2)
        `CHECK(lc, la)
        t_nest();
        stop_test();
    end
endmodule
`default_nettype wire
